/* verilog/i2c_seq_pkg.sv */
// constants, types and register map of the i2c master sequencer
// assumes one 200 MHz clock; one rate tick per rising clock edge
package i2c_seq_pkg;

	// ==========================================================
	// register map (byte addresses, one word each)
	localparam int          ADDR_W      = 5;
	localparam logic [4:0]  OFF_CTRL2   = 5'h00; // control2_reg
	localparam logic [4:0]  OFF_STATUS  = 5'h04; // port_status_reg
	localparam logic [4:0]  OFF_RATE    = 5'h08; // rate_reload_reg
	localparam logic [4:0]  OFF_BUF     = 5'h0C; // shift_buffer_reg
	localparam logic [4:0]  OFF_FLAGS   = 5'h10; // event flags

	// ==========================================================
	// field positions
	localparam int C2_START   = 0; // start_request
	localparam int C2_RESTART = 1; // restart_request
	localparam int C2_RECV    = 3; // receive_request
	localparam int C2_ACKSEQ  = 4; // ack_sequence_request
	localparam int C2_ACKVAL  = 5; // ack_value_select
	localparam int C2_ACK_RECEIVED_STATUS = 6; // ack_received_status
	localparam int CMD_W      = 5; // guarded command field width
	localparam int ST_BF      = 0; // buffer_full_flag
	localparam int ST_START   = 3; // start detected
	localparam int FL_EVT     = 0; // port_event_flag
	localparam int FL_BCL     = 1; // bus_collision_flag
	localparam int FL_WRITE_COLLISION_FLAG    = 2; // write_collision_flag
	localparam int FL_OVF     = 3; // receive_overflow_flag

	// ==========================================================
	// widths, reset values, counts
	localparam int          RATE_W      = 7;
	localparam int          RS_RATE_W   = 6;
	localparam logic [6:0]  RATE_RST    = 7'h09;
	localparam logic [3:0]  BITS_BYTE   = 4'h8;
	localparam logic [3:0]  LAST_BIT    = 4'h7;
	localparam int          SYNC_LEN    = 3;

	// ==========================================================
	// sequencer states
	typedef enum logic [3:0] {
		IDLE    = 4'b0000,
		S_CHK   = 4'b0001,
		S_HOLD  = 4'b0010,
		R_SCLDN = 4'b0011,
		R_SDAUP = 4'b0100,
		R_SCLUP = 4'b0101,
		R_BOTH  = 4'b0110,
		R_SDADN = 4'b0111,
		B_FALL  = 4'b1000,
		B_LOW   = 4'b1001,
		B_REL   = 4'b1010,
		B_HIGH  = 4'b1011
	} state_t;

	// byte-level operation in progress
	typedef enum logic [1:0] {
		OP_TX  = 2'b00,
		OP_RX  = 2'b01,
		OP_ACK = 2'b10
	} op_t;

	// sticky event flags
	typedef struct packed {
		logic ovf;
		logic write_collision_flag;
		logic bcl;
		logic evt;
	} flags_t;

	// open-drain pull-down requests
	typedef struct packed {
		logic sclLow;
		logic sdaLow;
	} lineDrive_t;

endpackage

/* verilog/rate_counter.sv */
// reloadable down counter that paces every bus phase
// assumes the sequencer loads it and reacts to done in that cycle
`timescale 1ns/1ps
module rate_counter #(
	parameter int W = 7
) (
	input  wire logic         clock,
	input  wire logic         rst_b,
	input  wire logic         load,
	input  wire logic [W-1:0] reloadVal,
	output logic              done,
	output logic              running
);

	logic [W-1:0] cnt_q;
	logic         run_q;

	// ==========================================================
	// timeout when a running count reaches zero
	assign done    = run_q & (cnt_q == '0);
	assign running = run_q;

	// reload wins; otherwise count down and stop at zero
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (load) begin
			cnt_q <= reloadVal;
			run_q <= 1'b1;
		end else if (run_q) begin
			cnt_q <= (cnt_q == '0) ? cnt_q : cnt_q - 1'b1;
			run_q <= (cnt_q != '0);
		end
	end

endmodule // rate_counter

/* verilog/i2c_master_sequencer.sv */
// i2c master sequencer: start, repeated start, byte tx/rx, ack
// assumes an Avalon-MM master and open-drain SCL/SDA with pull-ups
//
// How it works
// RL1: start request with both lines high reloads the counter from seven bits.
// RL2: timeout with lines high pulls SDA low and sets start detected.
// RL3: one more period, then clear start request, stop counter, SDA low.
// RL4: lines low at start or SCL low early flags collision, aborts.
// RL5: low five control bits ignore writes during start or restart.
// RL6: restart pulls SCL low, then loads six bits, releases SDA.
// RL7: SDA high releases SCL; both high one period; SDA low; done.
// RL8: start detected set at once; restart event only after timeout.
// RL9: restart ignored when busy; SDA low at SCL rise collides.
// RL10: software loads the address byte after the event flag.
// RL11: buffer write sets full and shifts bits, low then high period.
// RL12: eighth fall clears full, releases SDA; ninth samples acknowledge.
// RL13: after ninth clock set event, hold SCL low, stop counter.
// RL14: buffer full set by buffer write, cleared after eight bits out.
// RL15: buffer write while busy sets write collision; software clears it.
// RL16: receive request acts only when idle.
// RL17: rollovers toggle SCL, shift SDA in; eighth fall completes byte.
// RL18: receive sets buffer full; buffer read clears it.
// RL19: new byte while buffer full sets receive overflow.
// RL20: ack request pulls SCL low and drives the ack value.
// RL21: ack: one period low, release, one period high, low, idle.
// RL22: counter counts down from reload to zero then stops.
// RL23: counting after SCL release waits until SCL is sampled high.
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module i2c_master_sequencer (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic [4:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	input  wire logic        sclIn,
	output logic             sclOut,
	output logic             sclOe_b,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe_b
);

	// ==========================================================
	// pin synchronisers
	logic [1:0]              lineRaw;
	logic [1:0]              line_q;
	logic [i2c_seq_pkg::SYNC_LEN-1:0] sync_q [2];
	logic                    sclF;
	logic                    sdaF;

	assign lineRaw = {sdaIn, sclIn};
	assign sclF    = line_q[0];
	assign sdaF    = line_q[1];

	// three stages; a change counts when stages two and three agree
	for (genvar i = 0; i < 2; i++) begin : gSync
		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b) begin
				sync_q[i] <= '1;
				line_q[i] <= 1'b1;
			end else begin
				sync_q[i] <= {sync_q[i][1:0], lineRaw[i]};
				if (sync_q[i][1] == sync_q[i][2])
					line_q[i] <= sync_q[i][2];
			end
		end
	end

	// ==========================================================
	// bus slave: one wait cycle, then the access completes
	logic req;
	logic resp_q;
	logic acc;
	logic hitCtrl;
	logic hitStat;
	logic hitRate;
	logic hitBuf;
	logic hitFlag;

	assign req         = read | write;
	assign acc         = req & resp_q;
	assign waitrequest = req & ~resp_q;
	assign hitCtrl     = (address == i2c_seq_pkg::OFF_CTRL2);
	assign hitStat     = (address == i2c_seq_pkg::OFF_STATUS);
	assign hitRate     = (address == i2c_seq_pkg::OFF_RATE);
	assign hitBuf      = (address == i2c_seq_pkg::OFF_BUF);
	assign hitFlag     = (address == i2c_seq_pkg::OFF_FLAGS);

	logic wrCtrl;
	logic wrRate;
	logic wrBuf;
	logic wrFlag;
	logic rdBuf;

	assign wrCtrl = write & acc & hitCtrl;
	assign wrRate = write & acc & hitRate;
	assign wrBuf  = write & acc & hitBuf;
	assign wrFlag = write & acc & hitFlag;
	assign rdBuf  = read & acc & hitBuf;

	// ==========================================================
	// state
	i2c_seq_pkg::state_t     state_q;
	i2c_seq_pkg::state_t     state_d;
	i2c_seq_pkg::op_t        op_q;
	i2c_seq_pkg::op_t        op_d;
	i2c_seq_pkg::flags_t     flags_q;
	i2c_seq_pkg::flags_t     flagSet;
	i2c_seq_pkg::lineDrive_t drv_q;
	i2c_seq_pkg::lineDrive_t drv_d;
	logic [4:0]              cmd_q;
	logic [4:0]              cmdClr;
	logic                    ackVal_q;
	logic                    ack_received_status_q;
	logic                    ack_received_status_d;
	logic                    startDet_q;
	logic                    setSd;
	logic                    clrSd;
	logic                    bf_q;
	logic                    bfSet;
	logic                    bfClr;
	logic [6:0]              rate_q;
	logic [7:0]              buf_q;
	logic [7:0]              sh_q;
	logic [7:0]              sh_d;
	logic [3:0]              bit_q;
	logic [3:0]              bit_d;
	logic                    ld;
	logic [6:0]              ldVal;
	logic                    tmo;
	logic                    busy;
	logic                    txGo;

	// busy covers any sequence running or a request not yet taken
	assign busy = (state_q != i2c_seq_pkg::IDLE) | (cmd_q[4:3] != 2'b00)
		| (cmd_q[1:0] != 2'b00);
	assign txGo = wrBuf & ~busy; // RL11

	rate_counter #(
		.W         (i2c_seq_pkg::RATE_W)
	) uRate (
		.clock     (clock),
		.rst_b     (rst_b),
		.load      (ld),
		.reloadVal (ldVal),
		.done      (tmo),
		.running   ()
	); // RL22

	// ==========================================================
	// sequencer
	always_comb begin
		state_d   = state_q;
		op_d      = op_q;
		drv_d     = drv_q;
		ld        = 1'b0;
		ldVal     = rate_q;
		flagSet   = '0;
		cmdClr    = '0;
		setSd     = 1'b0;
		clrSd     = 1'b0;
		bfSet     = 1'b0;
		bfClr     = 1'b0;
		ack_received_status_d = ack_received_status_q;
		sh_d      = sh_q;
		bit_d     = bit_q;
		case (state_q)
			i2c_seq_pkg::IDLE: begin
				bit_d = 4'h0;
				if (txGo) begin
					sh_d         = writedata[7:0];
					op_d         = i2c_seq_pkg::OP_TX;
					drv_d.sclLow = 1'b1;
					state_d      = i2c_seq_pkg::B_FALL;
				end else if (cmd_q[i2c_seq_pkg::C2_START]) begin
					if (sdaF & sclF) begin
						ld      = 1'b1; // RL1
						state_d = i2c_seq_pkg::S_CHK;
					end else begin
						flagSet.bcl = 1'b1; // RL4
						cmdClr      = '1;
						clrSd       = 1'b1;
						drv_d       = '0;
					end
				end else if (cmd_q[i2c_seq_pkg::C2_RESTART]) begin
					drv_d.sclLow = 1'b1; // RL6
					state_d      = i2c_seq_pkg::R_SCLDN;
				end else if (cmd_q[i2c_seq_pkg::C2_RECV]) begin
					op_d         = i2c_seq_pkg::OP_RX; // RL16
					drv_d.sclLow = 1'b1;
					state_d      = i2c_seq_pkg::B_FALL;
				end else if (cmd_q[i2c_seq_pkg::C2_ACKSEQ]) begin
					op_d         = i2c_seq_pkg::OP_ACK;
					drv_d.sclLow = 1'b1; // RL20
					state_d      = i2c_seq_pkg::B_FALL;
				end
			end
			i2c_seq_pkg::S_CHK: begin
				if (!sclF) begin
					flagSet.bcl = 1'b1; // RL4
					cmdClr      = '1;
					clrSd       = 1'b1;
					drv_d       = '0;
					state_d     = i2c_seq_pkg::IDLE;
				end else if (tmo || !sdaF) begin
					drv_d.sdaLow = 1'b1; // RL2
					setSd        = 1'b1; // RL8
					ld           = 1'b1; // RL3
					state_d      = i2c_seq_pkg::S_HOLD;
				end
			end
			i2c_seq_pkg::S_HOLD: begin
				if (tmo) begin
					cmdClr[i2c_seq_pkg::C2_START] = 1'b1; // RL3
					flagSet.evt = 1'b1;
					state_d     = i2c_seq_pkg::IDLE;
				end
			end
			i2c_seq_pkg::R_SCLDN: begin
				if (!sclF) begin
					ldVal        = {1'b0, rate_q[5:0]}; // RL6
					ld           = 1'b1;
					drv_d.sdaLow = 1'b0;
					state_d      = i2c_seq_pkg::R_SDAUP;
				end
			end
			i2c_seq_pkg::R_SDAUP: begin
				if (tmo && sdaF) begin
					drv_d.sclLow = 1'b0; // RL7
					state_d      = i2c_seq_pkg::R_SCLUP;
				end else if (tmo) begin
					flagSet.bcl = 1'b1; // RL9
					cmdClr      = '1;
					clrSd       = 1'b1;
					drv_d       = '0;
					state_d     = i2c_seq_pkg::IDLE;
				end
			end
			i2c_seq_pkg::R_SCLUP: begin
				if (sclF && !sdaF) begin
					flagSet.bcl = 1'b1; // RL9
					cmdClr      = '1;
					clrSd       = 1'b1;
					drv_d       = '0;
					state_d     = i2c_seq_pkg::IDLE;
				end else if (sclF) begin
					ld      = 1'b1; // RL7 RL23
					state_d = i2c_seq_pkg::R_BOTH;
				end
			end
			i2c_seq_pkg::R_BOTH: begin
				if (!sclF) begin
					flagSet.bcl = 1'b1; // RL9
					cmdClr      = '1;
					clrSd       = 1'b1;
					drv_d       = '0;
					state_d     = i2c_seq_pkg::IDLE;
				end else if (tmo || !sdaF) begin
					drv_d.sdaLow = 1'b1; // RL7
					setSd        = 1'b1; // RL8
					ld           = 1'b1;
					state_d      = i2c_seq_pkg::R_SDADN;
				end
			end
			i2c_seq_pkg::R_SDADN: begin
				if (tmo) begin
					cmdClr[i2c_seq_pkg::C2_RESTART] = 1'b1; // RL7
					flagSet.evt = 1'b1; // RL8
					state_d     = i2c_seq_pkg::IDLE;
				end
			end
			i2c_seq_pkg::B_FALL: begin
				// change SDA only once SCL is seen low
				if (!sclF) begin
					ld = 1'b1; // RL11
					if (op_q == i2c_seq_pkg::OP_TX)
						drv_d.sdaLow = (bit_q < i2c_seq_pkg::BITS_BYTE)
							& ~sh_q[7]; // RL12
					else if (op_q == i2c_seq_pkg::OP_ACK)
						drv_d.sdaLow = ~ackVal_q; // RL20
					else
						drv_d.sdaLow = 1'b0;
					state_d = i2c_seq_pkg::B_LOW;
				end
			end
			i2c_seq_pkg::B_LOW: begin
				if (tmo) begin
					drv_d.sclLow = 1'b0; // RL21
					state_d      = i2c_seq_pkg::B_REL;
				end
			end
			i2c_seq_pkg::B_REL: begin
				if (sclF) begin
					ld      = 1'b1; // RL23
					state_d = i2c_seq_pkg::B_HIGH;
				end
			end
			i2c_seq_pkg::B_HIGH: begin
				if (tmo) begin
					drv_d.sclLow = 1'b1; // RL17
					bit_d        = bit_q + 4'h1;
					state_d      = i2c_seq_pkg::B_FALL;
					case (op_q)
						i2c_seq_pkg::OP_TX: begin
							sh_d = {sh_q[6:0], 1'b0};
							if (bit_q == i2c_seq_pkg::LAST_BIT)
								bfClr = 1'b1; // RL12 RL14
							if (bit_q == i2c_seq_pkg::BITS_BYTE) begin
								ack_received_status_d   = sdaF; // RL12
								flagSet.evt = 1'b1; // RL13
								state_d     = i2c_seq_pkg::IDLE;
							end
						end
						i2c_seq_pkg::OP_RX: begin
							sh_d = {sh_q[6:0], sdaF}; // RL17
							if (bit_q == i2c_seq_pkg::LAST_BIT) begin
								bfSet       = 1'b1; // RL18
								flagSet.ovf = bf_q; // RL19
								flagSet.evt = 1'b1;
								cmdClr[i2c_seq_pkg::C2_RECV] = 1'b1;
								state_d     = i2c_seq_pkg::IDLE;
							end
						end
						default: begin
							cmdClr[i2c_seq_pkg::C2_ACKSEQ] = 1'b1; // RL21
							flagSet.evt = 1'b1; // RL21
							state_d = i2c_seq_pkg::IDLE;
						end
					endcase
				end
			end
			default: begin
				state_d = i2c_seq_pkg::IDLE;
			end
		endcase
		flagSet.write_collision_flag = wrBuf & busy; // RL15
	end

	// ==========================================================
	// state registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_q   <= i2c_seq_pkg::IDLE;
			op_q      <= i2c_seq_pkg::OP_TX;
			drv_q     <= '0;
			sh_q      <= 8'h00;
			bit_q     <= 4'h0;
			ack_received_status_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			op_q      <= op_d;
			drv_q     <= drv_d;
			sh_q      <= sh_d;
			bit_q     <= bit_d;
			ack_received_status_q <= ack_received_status_d;
		end
	end

	// command bits: writable only while nothing runs or waits; ack value taken on every write
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cmd_q    <= 5'h00;
			ackVal_q <= 1'b0;
		end else begin
			if (wrCtrl && !busy)
				cmd_q <= writedata[4:0]; // RL5 RL9 RL16
			else
				cmd_q <= cmd_q & ~cmdClr;
			if (wrCtrl)
				ackVal_q <= writedata[i2c_seq_pkg::C2_ACKVAL];
		end
	end

	// buffer, rate reload and status; hardware set wins over clear
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			buf_q      <= 8'h00;
			rate_q     <= i2c_seq_pkg::RATE_RST;
			bf_q       <= 1'b0;
			startDet_q <= 1'b0;
			flags_q    <= '0;
		end else begin
			if (txGo)
				buf_q <= writedata[7:0]; // RL15
			else if (bfSet)
				buf_q <= sh_d;
			if (wrRate)
				rate_q <= writedata[6:0];
			bf_q       <= txGo | bfSet | (bf_q & ~bfClr & ~rdBuf); // RL14 RL18
			startDet_q <= setSd | (startDet_q & ~clrSd);
			flags_q    <= flagSet | (flags_q
				& ~(wrFlag ? writedata[3:0] : 4'h0)); // RL15
		end
	end

	// ==========================================================
	// read data captured during the wait cycle
	logic [31:0] rdMux;

	assign rdMux =
		hitCtrl ? {25'h0, ack_received_status_q, ackVal_q, cmd_q} :
		hitStat ? {28'h0, startDet_q, 2'b00, bf_q} :
		hitRate ? {25'h0, rate_q} :
		hitBuf  ? {24'h0, buf_q} :
		hitFlag ? {28'h0, flags_q} : 32'h0000_0000;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			resp_q   <= 1'b0;
			readdata <= 32'h0000_0000;
		end else begin
			resp_q <= req & ~resp_q;
			if (read && !resp_q)
				readdata <= rdMux;
		end
	end

	// open-drain pins: enable low pulls the line low
	assign sclOut  = 1'b0;
	assign sdaOut  = 1'b0;
	assign sclOe_b = ~drv_q.sclLow;
	assign sdaOe_b = ~drv_q.sdaLow;

endmodule // i2c_master_sequencer

/* testbench/i2c_master_sequencer_checker.sv */
// assertions on the bus and line pins of the sequencer
// assumes binding into i2c_master_sequencer, one clock domain
`timescale 1ns/1ps
module i2c_master_sequencer_checker (
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic [4:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        sclIn,
	input wire logic        sclOut,
	input wire logic        sclOe_b,
	input wire logic        sdaIn,
	input wire logic        sdaOut,
	input wire logic        sdaOe_b
);
	// ==========================================================
	// shadows of written fields, scl phase lengths
	logic [6:0] rateQ;
	logic [7:0] highCnt;
	logic [7:0] lowCnt;
	logic       ackV;
	wire        wrDone = write && !waitrequest;
	wire        ctrlWr = wrDone && address == i2c_seq_pkg::OFF_CTRL2;
	wire        rateWr = wrDone && address == i2c_seq_pkg::OFF_RATE;
	wire        ackWr  = ctrlWr && writedata[i2c_seq_pkg::C2_ACKSEQ];

	// saturating phase counters, latched fields
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rateQ <= i2c_seq_pkg::RATE_RST;
			ackV <= 1'b0;
			highCnt <= 8'h00;
			lowCnt <= 8'h00;
		end else begin
			rateQ <= rateWr ? writedata[6:0] : rateQ;
			ackV <= ackWr ? writedata[i2c_seq_pkg::C2_ACKVAL] : ackV;
			highCnt <= (sclOe_b && sclIn) ? highCnt + {7'h00, ~&highCnt} : 8'h00;
			lowCnt <= !sclOe_b ? lowCnt + {7'h00, ~&lowCnt} : 8'h00;
		end
	end

	// ==========================================================
	// properties
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	sequence reqSeen;
		$rose(read || write);
	endsequence
	sequence sdaHeldLow;
		!sdaIn [*4];
	endsequence
	sequence startWr;
		ctrlWr && writedata[i2c_seq_pkg::C2_START];
	endsequence
	sequence startEdge;
		$fell(sdaOe_b) && sclOe_b;
	endsequence

	bus_wait_once_a: assert property (reqSeen |-> waitrequest ##1 !waitrequest)
		else $error("bus answer not after one wait cycle");
	open_drain_a: assert property (!sclOut && !sdaOut)
		else $error("line driven high");
	start_on_high_a: assert property (startEdge |-> $past(sclIn, 4))
		else $error("sda pulled without scl high");
	start_hold_a: assert property (startEdge |=> !sdaOe_b [*2])
		else $error("sda not held low after start edge");
	start_collide_a: assert property (sdaHeldLow ##0 startWr
		|=> (sdaOe_b && sclOe_b) [*8])
		else $error("start went on with sda low");
	scl_stretch_a: assert property (sclOe_b && !sclIn |=> sclOe_b)
		else $error("scl pulled while still stretched");
	scl_high_a: assert property ($fell(sclOe_b) |-> highCnt > {1'b0, rateQ})
		else $error("scl high phase too short");
	scl_low_a: assert property ($rose(sclOe_b) |-> lowCnt >= {1'b0, rateQ})
		else $error("scl low phase too short");
	ack_drive_a: assert property (ackWr |-> ##[1:8] (!sclOe_b && sdaOe_b == ackV))
		else $error("ack value not on sda");
endmodule // i2c_master_sequencer_checker

bind i2c_master_sequencer i2c_master_sequencer_checker u_checker (
	.clock(clock), .rst_b(rst_b), .address(address), .read(read),
	.write(write), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .sclIn(sclIn), .sclOut(sclOut),
	.sclOe_b(sclOe_b), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_b(sdaOe_b));

/* testbench/i2c_slave_model.sv */
// slave stand-in: acks bytes, sends bytes, may stretch scl
// assumes wired-and lines with pull-ups made by the bench
`timescale 1ns/1ps
module i2c_slave_model (
	input  wire logic       sclW,
	input  wire logic       sdaW,
	input  wire logic       rxMode,
	input  wire logic       ackOn,
	input  wire logic       stretch,
	input  wire logic [7:0] txByte,
	output logic            sclOe_b,
	output logic            sdaOe_b
);
	int riseCnt = 0;
	initial begin
		sclOe_b = 1'b1;
		sdaOe_b = 1'b1;
	end
	// ==========================================================
	// rise count restarts at a start edge or a new read
	always @(negedge sdaW) if (sclW) riseCnt = 0;
	always @(posedge sclW) riseCnt = riseCnt + 1;
	always @(posedge rxMode) begin
		riseCnt = 0;
		sdaOe_b = txByte[7];
	end
	// data changes only while scl is low; slot follows rises seen
	always @(negedge sclW) begin
		if (rxMode)
			sdaOe_b = (riseCnt < 8) ? txByte[7 - riseCnt] : 1'b1;
		else
			sdaOe_b = !(ackOn && riseCnt == 8);
		if (riseCnt >= 9) riseCnt = 0;
		if (stretch) begin
			sclOe_b = 1'b0;
			#60 sclOe_b = 1'b1;
		end
	end
endmodule // i2c_slave_model

/* testbench/test_i2c_master_sequencer.sv */
// self-checking bench of the i2c master sequencer
// assumes the slave model and the bound checker
`timescale 1ns/1ps
module test_i2c_master_sequencer;
	logic        clock = 1'b0;
	logic        rst_b = 1'b0;
	logic [4:0]  address = 5'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic        waitrequest, sclOut, sclOe_b, sdaOut, sdaOe_b;
	logic        slvSclOe_b, slvSdaOe_b;
	logic        rxMode = 1'b0, ackOn = 1'b1, stretch = 1'b0;
	logic        holdSda = 1'b0;
	logic [7:0]  txByte = 8'h00;
	logic [8:0]  cap = 9'h000;
	logic [31:0] q, d;
	int          err_count = 0;
	int          comparisons = 0;
	wire         sclW = sclOe_b & slvSclOe_b;
	wire         sdaW = sdaOe_b & slvSdaOe_b & !holdSda;

	i2c_master_sequencer u_i2c_master_sequencer (
		.clock(clock), .rst_b(rst_b), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .sclIn(sclW), .sclOut(sclOut),
		.sclOe_b(sclOe_b), .sdaIn(sdaW), .sdaOut(sdaOut),
		.sdaOe_b(sdaOe_b));
	i2c_slave_model u_i2c_slave_model (
		.sclW(sclW), .sdaW(sdaW), .rxMode(rxMode), .ackOn(ackOn),
		.stretch(stretch), .txByte(txByte), .sclOe_b(slvSclOe_b),
		.sdaOe_b(slvSdaOe_b));

	// ==========================================================
	// clock, wire monitor, checking tasks
	always #2.5 clock = ~clock;
	always @(posedge sclW) cap = {cap[7:0], sdaW};

	task automatic chk(input string nm, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clock);
		write <= wr;
		read <= !wr;
		address <= a;
		writedata <= v;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
		if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
	endtask
	task automatic waitEvt();
		int n;
		n = 0;
		do begin
			bus(1'b0, i2c_seq_pkg::OFF_FLAGS, 32'h0);
			n++;
		end while (q[i2c_seq_pkg::FL_EVT] !== 1'b1 && n < 400);
		if (n >= 400) chk("event", 32'h1, 32'h0);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==========================================================
	// watchdog
	initial begin
		#400000;
		err_count++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		void'($urandom(32'h797D557C));
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		bus(1'b0, i2c_seq_pkg::OFF_RATE, 32'h0);
		chk("rate", {25'h0, i2c_seq_pkg::RATE_RST}, q);
		bus(1'b1, 5'h14, 32'hFFFFFFFF);
		bus(1'b0, 5'h14, 32'h0);
		chk("unmapped", 32'h0, q);
		bus(1'b1, i2c_seq_pkg::OFF_RATE, 32'h2 + ($urandom % 4));
		// start against a held-low sda
		holdSda <= 1'b1;
		repeat (6) @(posedge clock);
		bus(1'b1, i2c_seq_pkg::OFF_CTRL2, 32'h1);
		repeat (10) @(posedge clock);
		bus(1'b0, i2c_seq_pkg::OFF_FLAGS, 32'h0);
		chk("flags", 32'h2, q);
		bus(1'b0, i2c_seq_pkg::OFF_CTRL2, 32'h0);
		chk("ctrl2", 32'h0, q);
		holdSda <= 1'b0;
		bus(1'b1, i2c_seq_pkg::OFF_FLAGS, 32'hF);
		// start with refused writes meanwhile
		bus(1'b1, i2c_seq_pkg::OFF_CTRL2, 32'h1);
		bus(1'b1, i2c_seq_pkg::OFF_CTRL2, 32'h9);
		bus(1'b1, i2c_seq_pkg::OFF_BUF, 32'hA5);
		waitEvt();
		chk("flags", 32'h5, q);
		bus(1'b0, i2c_seq_pkg::OFF_CTRL2, 32'h0);
		chk("ctrl2", 32'h0, q);
		bus(1'b0, i2c_seq_pkg::OFF_STATUS, 32'h0);
		chk("status", 32'h8, q);
		chk("sdaOe_b", 32'h0, sdaOe_b);
		bus(1'b1, i2c_seq_pkg::OFF_FLAGS, 32'hF);
		// bytes out, acked then not acked, slave stretching
		stretch <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			d = (i == 0) ? 32'hFF : {24'h0, 8'($urandom)};
			ackOn <= (i == 0);
			bus(1'b1, i2c_seq_pkg::OFF_BUF, d);
			bus(1'b0, i2c_seq_pkg::OFF_STATUS, 32'h0);
			chk("status", 32'h9, q);
			bus(1'b1, i2c_seq_pkg::OFF_BUF, 32'h0);
			waitEvt();
			chk("flags", 32'h5, q);
			chk("byte", d, {24'h0, cap[8:1]});
			bus(1'b0, i2c_seq_pkg::OFF_CTRL2, 32'h0);
			chk("ctrl2", i ? 32'h40 : 32'h0, q);
			bus(1'b0, i2c_seq_pkg::OFF_STATUS, 32'h0);
			chk("status", 32'h8, q);
			chk("sclOe_b", 32'h0, sclOe_b);
			bus(1'b1, i2c_seq_pkg::OFF_FLAGS, 32'hF);
		end
		// repeated start
		bus(1'b1, i2c_seq_pkg::OFF_CTRL2, 32'h2);
		waitEvt();
		bus(1'b0, i2c_seq_pkg::OFF_CTRL2, 32'h0);
		chk("ctrl2", 32'h40, q);
		chk("sdaOe_b", 32'h0, sdaOe_b);
		bus(1'b1, i2c_seq_pkg::OFF_FLAGS, 32'hF);
		// three receives, the last overruns an unread byte
		for (int i = 0; i < 3; i++) begin
			d = {24'h0, 8'($urandom)};
			txByte <= d[7:0];
			rxMode <= 1'b1;
			bus(1'b1, i2c_seq_pkg::OFF_CTRL2, 32'h8);
			waitEvt();
			rxMode <= 1'b0;
			chk("flags", (i == 2) ? 32'h9 : 32'h1, q);
			bus(1'b1, i2c_seq_pkg::OFF_FLAGS, 32'hF);
			if (i == 0) begin
				bus(1'b0, i2c_seq_pkg::OFF_STATUS, 32'h0);
				chk("status", 32'h9, q);
				bus(1'b0, i2c_seq_pkg::OFF_BUF, 32'h0);
				chk("rxbyte", d, q);
				bus(1'b0, i2c_seq_pkg::OFF_STATUS, 32'h0);
				chk("status", 32'h8, q);
			end
		end
		// acknowledge sequence with both values
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, i2c_seq_pkg::OFF_CTRL2, i ? 32'h30 : 32'h10);
			waitEvt();
			chk("ackbit", i, {31'h0, cap[0]});
			bus(1'b0, i2c_seq_pkg::OFF_CTRL2, 32'h0);
			chk("ctrl2", i ? 32'h60 : 32'h40, q);
			chk("sclOe_b", 32'h0, sclOe_b);
			bus(1'b1, i2c_seq_pkg::OFF_FLAGS, 32'hF);
		end
		tally_and_finish();
	end
endmodule // test_i2c_master_sequencer
